/* File: verilog/orf_defs.svh */
`ifndef ORF_DEFS_SVH
`define ORF_DEFS_SVH

// register byte offsets on the bus
`define ORF_OFS_INSTR 8'h00
`define ORF_OFS_ACCUM 8'h04
`define ORF_OFS_STATUS 8'h08
`define ORF_OFS_MEMADDR 8'h0C
`define ORF_OFS_MEMDATA 8'h10
`define ORF_OFS_EXECCNT 8'h14

// status register fields
`define ORF_ST_ZERO 0
`define ORF_ST_BADOP 1

// reset values
`define ORF_RST_ACCUM 8'h00
`define ORF_RST_ZERO 1'b0

// instruction word fields
`define ORF_INSTR_W 14
`define ORF_OPC_HI 13
`define ORF_OPC_LO 8
`define ORF_DEST_BIT 7
`define ORF_FADDR_HI 6
`define ORF_OPC_OR 6'h04
`define ORF_OPC_COPY 6'h08
`define ORF_OPC_STORE 7'h01

// bus constants
`define ORF_HSIZE_WORD 3'h2
`define ORF_HRESP_OKAY 1'b0

`endif

/* File: verilog/orf_pkg.sv */
package orf_pkg;

  typedef enum logic [1:0] {
    ORF_OP_NONE = 2'b00,
    ORF_OP_OR = 2'b01,
    ORF_OP_COPY = 2'b10,
    ORF_OP_STORE = 2'b11
  } orf_op_t;

endpackage

/* File: verilog/orf_exec_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface orf_exec_if #(
  parameter int DW = 8
);
  import orf_pkg::*;
  orf_op_t op;
  logic dest;
  logic [DW-1:0] accum;
  logic [DW-1:0] regval;
  logic [DW-1:0] result;
  logic wr_accum;
  logic wr_reg;
  logic upd_zero;
  logic zero;

  modport core (
    output op, dest, accum, regval,
    input result, wr_accum, wr_reg, upd_zero, zero
  );
  modport alu (
    input op, dest, accum, regval,
    output result, wr_accum, wr_reg, upd_zero, zero
  );
endinterface

`default_nettype wire

/* File: verilog/orf_alu.sv */
`timescale 1ns/100ps
`default_nettype none

module orf_alu
  import orf_pkg::*;
(
  orf_exec_if.alu ex
);

  always_comb begin
    ex.result = ex.regval;
    ex.wr_accum = 1'b0;
    ex.wr_reg = 1'b0;
    ex.upd_zero = 1'b0;
    case (ex.op)
      ORF_OP_OR: begin
        ex.result = ex.accum | ex.regval; // see RQ1
        ex.wr_accum = ~ex.dest; // see RQ2
        ex.wr_reg = ex.dest; // see RQ2
        ex.upd_zero = 1'b1; // see RQ1
      end
      ORF_OP_COPY: begin
        ex.result = ex.regval; // see RQ3
        ex.wr_accum = ~ex.dest; // see RQ4
        ex.wr_reg = ex.dest; // see RQ4
        // the flag moves even when only the register is rewritten
        ex.upd_zero = 1'b1; // see RQ5
      end
      ORF_OP_STORE: begin
        ex.result = ex.accum; // see RQ6
        ex.wr_reg = 1'b1; // see RQ6
      end
      default: begin
        ex.result = ex.regval;
      end
    endcase
    ex.zero = (ex.result == '0);
  end

endmodule

`default_nettype wire

/* File: verilog/orf_core.sv */
`timescale 1ns/100ps
`default_nettype none
`include "orf_defs.svh"

// Function
// RQ1 - or accumulator with register, zero flag follows
// RQ2 - or result: dest 0 accumulator, 1 register
// RQ3 - copy register unchanged, zero flag follows
// RQ4 - copy: dest 0 accumulator, 1 register
// RQ5 - copy back to register still updates zero
// RQ6 - store accumulator to register, flags untouched (the code keeps zero but clears the bad_op status bit)
module orf_core
  import orf_pkg::*;
#(
  parameter int DW = 8,
  parameter int AW = 7
) (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  output logic [DW-1:0] accum_o,
  output logic zero_flag_o
);

  // the datapath and the bus map are built for these widths only
  if (DW != 8 || AW != 7) begin : g_bad_width
    $error("orf_core serves only DW=8 and AW=7");
  end

  localparam int DEPTH = 1 << AW;

  logic [DW-1:0] mem [DEPTH];
  logic [DW-1:0] accum;
  logic zero;
  logic bad_op;
  logic [AW-1:0] mem_addr;
  logic [`ORF_INSTR_W-1:0] instr;
  logic [15:0] exec_cnt;
  logic wr_pend;
  logic [7:0] wr_ofs;

  logic addr_ok;
  logic acc_phase;
  logic wr_go;
  logic ex_go;
  logic [`ORF_INSTR_W-1:0] new_instr;
  logic [AW-1:0] ex_faddr;
  orf_op_t ex_op;
  logic [31:0] next_rdata;
  logic wr_accum_go;
  logic wr_status_go;
  logic wr_maddr_go;
  logic wr_mdata_go;

  orf_exec_if #(.DW(DW)) ex ();

  function automatic orf_op_t decode_op(
    input logic [`ORF_INSTR_W-1:0] w
  );
    orf_op_t op;
    op = ORF_OP_NONE;
    if (w[`ORF_OPC_HI:`ORF_OPC_LO] == `ORF_OPC_OR) begin
      op = ORF_OP_OR;
    end else if (w[`ORF_OPC_HI:`ORF_OPC_LO] == `ORF_OPC_COPY) begin
      op = ORF_OP_COPY;
    end else if (w[`ORF_OPC_HI:`ORF_DEST_BIT] == `ORF_OPC_STORE) begin
      op = ORF_OP_STORE;
    end
    return op;
  endfunction

  function automatic logic [31:0] zext(input logic [DW-1:0] v);
    return {{(32-DW){1'b0}}, v};
  endfunction

  function automatic logic ofs_hit(
    input logic go,
    input logic [7:0] at,
    input logic [7:0] ofs
  );
    return go && (at == ofs);
  endfunction

  // bus address phase; only whole-word writes are honoured, reads of any size
  assign addr_ok = (haddr_i[31:8] == 24'h000000) &&
    (haddr_i[1:0] == 2'b00);
  assign acc_phase = hsel_i && htrans_i[1] && hready_i;
  assign wr_go = ce_i && wr_pend;

  // one strobe per register for the data phase of a bus write
  assign wr_accum_go = ofs_hit(wr_go, wr_ofs, `ORF_OFS_ACCUM);
  assign wr_status_go = ofs_hit(wr_go, wr_ofs, `ORF_OFS_STATUS);
  assign wr_maddr_go = ofs_hit(wr_go, wr_ofs, `ORF_OFS_MEMADDR);
  assign wr_mdata_go = ofs_hit(wr_go, wr_ofs, `ORF_OFS_MEMDATA);

  // instruction executes on the data phase of its write
  assign new_instr = hwdata_i[`ORF_INSTR_W-1:0];
  assign ex_faddr = new_instr[`ORF_FADDR_HI:0];
  assign ex_op = decode_op(new_instr);
  assign ex_go = ofs_hit(wr_go, wr_ofs, `ORF_OFS_INSTR);

  assign ex.op = ex_go ? ex_op : ORF_OP_NONE;
  assign ex.dest = new_instr[`ORF_DEST_BIT];
  assign ex.accum = accum;
  // an unwritten register reads unknown until software fills it
  assign ex.regval = mem[ex_faddr];

  orf_alu u_alu (
    .ex(ex.alu)
  );

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wr_pend <= 1'b0;
      wr_ofs <= 8'h00;
    end else if (ce_i) begin
      wr_pend <= acc_phase && hwrite_i && addr_ok &&
        (hsize_i == `ORF_HSIZE_WORD);
      wr_ofs <= haddr_i[7:0];
    end
  end

  always_comb begin
    next_rdata = 32'h00000000;
    if (addr_ok) begin
      case (haddr_i[7:0])
        `ORF_OFS_INSTR: next_rdata = {18'h00000, instr};
        `ORF_OFS_ACCUM: next_rdata = zext(accum);
        `ORF_OFS_STATUS: next_rdata = {30'h00000000, bad_op, zero};
        `ORF_OFS_MEMADDR: next_rdata = {25'h0000000, mem_addr};
        `ORF_OFS_MEMDATA: next_rdata = zext(mem[mem_addr]);
        `ORF_OFS_EXECCNT: next_rdata = {16'h0000, exec_cnt};
        default: next_rdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      hrdata_o <= 32'h00000000;
      hreadyout_o <= 1'b0;
      hresp_o <= `ORF_HRESP_OKAY;
    end else if (ce_i) begin
      hreadyout_o <= 1'b1;
      hresp_o <= `ORF_HRESP_OKAY;
      if (acc_phase && !hwrite_i) begin
        hrdata_o <= next_rdata;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      instr <= '0;
      bad_op <= 1'b0;
      exec_cnt <= 16'h0000;
    end else if (ex_go) begin
      instr <= new_instr;
      bad_op <= (ex_op == ORF_OP_NONE);
      if (ex_op != ORF_OP_NONE) begin
        exec_cnt <= exec_cnt + 16'h0001;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      accum <= `ORF_RST_ACCUM;
    end else if (ex_go && ex.wr_accum) begin
      accum <= ex.result; // see RQ2, see RQ4
    end else if (wr_accum_go) begin
      accum <= hwdata_i[DW-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      zero <= `ORF_RST_ZERO;
    end else if (ex_go && ex.upd_zero) begin
      // store leaves this flag alone: upd_zero is low for it
      zero <= ex.zero; // see RQ1, see RQ3, see RQ5, see RQ6
    end else if (wr_status_go) begin
      zero <= hwdata_i[`ORF_ST_ZERO];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      mem_addr <= '0;
    end else if (wr_maddr_go) begin
      mem_addr <= hwdata_i[AW-1:0];
    end
  end

  // register file: no reset, as in a plain data memory
  always_ff @(posedge sys_clk_i) begin
    if (ex_go && ex.wr_reg) begin
      mem[ex_faddr] <= ex.result; // see RQ2, see RQ4, see RQ6
    end else if (wr_mdata_go) begin
      mem[mem_addr] <= hwdata_i[DW-1:0];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      accum_o <= `ORF_RST_ACCUM;
      zero_flag_o <= `ORF_RST_ZERO;
    end else if (ce_i) begin
      accum_o <= accum;
      zero_flag_o <= zero;
    end
  end

endmodule

`default_nettype wire

/* File: sim/orf_core_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module orf_core_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  input wire logic hresp_o,
  input wire logic [7:0] accum_o,
  input wire logic zero_flag_o
);
  logic wq;
  // data phase of a word write to the instruction register
  always_ff @(posedge sys_clk_i) begin
    wq <= rst_n_i && ce_i && hsel_i && htrans_i[1] && hready_i && hwrite_i
      && haddr_i == 32'h0 && hsize_i == 3'h2;
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rst_n_i);
  sequence ins(logic [6:0] c);
    wq && hwdata_i[13:7] == c;
  endsequence
  sequence acc_kept;
    accum_o == $past(accum_o, 2);
  endsequence
  or_keeps_ones_a: assert property (ins(7'h08) |=> ##1
    (accum_o & $past(accum_o, 2)) == $past(accum_o, 2)
    && zero_flag_o == (accum_o == 8'h00)) else $error("or result wrong");
  or_to_reg_a: assert property (ins(7'h09) |=> ##1 acc_kept)
    else $error("or to register changed accumulator");
  copy_zero_a: assert property (ins(7'h10) |=> ##1
    zero_flag_o == (accum_o == 8'h00)) else $error("copy zero wrong");
  copy_back_a: assert property (ins(7'h11) |=> ##1 acc_kept)
    else $error("copy back changed accumulator");
  store_keeps_a: assert property (ins(7'h01) |=> ##1 acc_kept
    and zero_flag_o == $past(zero_flag_o, 2)) else $error("store bad");
  bus_ready_a: assert property ($past(rst_n_i) |-> hreadyout_o && !hresp_o)
    else $error("bus not ready or not okay");
endmodule
bind orf_core orf_core_asserts i_chk (.*);
`default_nettype wire

/* File: sim/orf_ref_model.sv */
`timescale 1ns/100ps
`default_nettype none
module orf_ref_model;
  logic [7:0] acc = 8'h00;
  logic z = 1'b0;
  logic [7:0] mem [128];
  task automatic exec(input logic [13:0] w);
    logic [7:0] r;
    r = w[13:8] == 6'h04 ? acc | mem[w[6:0]] : mem[w[6:0]];
    if (w[13:7] == 7'h01) begin
      mem[w[6:0]] = acc;
    end else begin
      z = r == 8'h00;
      if (w[7]) mem[w[6:0]] = r;
      else acc = r;
    end
  endtask
endmodule
`default_nettype wire

/* File: sim/test_or_move_file_register_ops.sv */
`timescale 1ns/100ps
`default_nettype none
module test_or_move_file_register_ops;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic rd_q = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h0;
  logic [8:0] pin_q [$];
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic [31:0] seed = 32'h47;
  logic [31:0] exp_q [$];
  logic hready, hresp, z_o;
  logic [7:0] acc_o;
  int n_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  always #50 clk = ~clk;
  orf_ref_model i_ref ();
  orf_core i_dut (.sys_clk_i(clk), .rst_n_i(rst_n), .ce_i(1'b1),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .accum_o(acc_o),
    .zero_flag_o(z_o));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL hrdata expected %h seen %h", e, s);
    end
  endtask
  task automatic chk_pin(input string nm, input logic [7:0] e,
    input logic [7:0] s);
    n_tests++;
    if (s !== e) begin
      n_errors++;
      $display("FAIL %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input logic w, logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    rd_q <= !w;
    do @(posedge clk); while (hready !== 1'b1);
    rd_q <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    pin_q.push_back({i_ref.z, i_ref.acc});
    xfer(a, 1'b0, 32'h0);
  endtask
  always @(posedge clk) begin
    logic [8:0] p;
    cyc++;
    if (cyc > 3000) begin
      n_errors++;
      end_of_test();
    end else if (rd_q && hready) begin
      chk(exp_q.pop_front(), hrdata);
      p = pin_q.pop_front();
      chk_pin("accum_o", p[7:0], acc_o);
      chk_pin("zero_flag_o", {7'h00, p[8]}, {7'h00, z_o});
    end
  end
  initial begin
    logic [31:0] r;
    logic [13:0] w;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd(8'h40, 32'h0);
    for (int i = 0; i < 45; i++) begin
      r = rnd();
      i_ref.acc = r[15] ? 8'h00 : r[7:0];
      i_ref.mem[r[22:16]] = r[31] ? 8'h00 : r[30:23];
      xfer(8'h04, 1'b1, {24'h0, i_ref.acc});
      xfer(8'h0C, 1'b1, {25'h0, r[22:16]});
      xfer(8'h10, 1'b1, {24'h0, i_ref.mem[r[22:16]]});
      w[13:8] = i % 3 == 0 ? 6'h04 : i % 3 == 1 ? 6'h08 : 6'h00;
      w[7] = i % 3 == 2 || r[8];
      w[6:0] = r[22:16];
      xfer(8'h00, 1'b1, {18'h0, w});
      i_ref.exec(w);
      rd(8'h04, {24'h0, i_ref.acc});
      rd(8'h08, {31'h0, i_ref.z});
      rd(8'h10, {24'h0, i_ref.mem[r[22:16]]});
    end
    xfer(8'h00, 1'b1, 32'h00003FFF);
    rd(8'h08, {30'h0, 1'b1, i_ref.z});
    rd(8'h14, 32'h0000002D);
    end_of_test();
  end
endmodule
`default_nettype wire
